// >>> design/nbv_host.sv
/*
 * Host sequencer: reads and programs pages and erases blocks of an 8-bit NAND
 * flash, keeps the bad-block table, the good-block count and the
 * partial-program counts per page.
 * Assumes inputs synchronous to core_clk and a ready/busy pin pulled up.
 */
`timescale 1ns/1ns
module nbv_host
    import nbv_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [1:0] cmdOp,
    input wire logic [9:0] cmdBlock,
    input wire logic [3:0] cmdPage,
    input wire logic cmdSpare,
    input wire logic [7:0] cmdCol,
    input wire logic [8:0] cmdLen,
    input wire logic [7:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic doneValid,
    output logic doneErr,
    output logic [10:0] goodBlockCount,
    output logic cle,
    output logic ale,
    output logic ceN,
    output logic weN,
    output logic readStrobeN,
    output logic wpN,
    output logic [7:0] ioOut,
    output logic ioOe,
    input wire logic [7:0] ioIn,
    input wire logic readyBusyN
);
    nbv_state_e state;
    nbv_state_e next_state;
    nbv_op_e op;
    logic [1:0] ph;
    logic [8:0] idx;
    logic [9:0] blk;
    logic [3:0] pg;
    logic spare;
    logic [7:0] col;
    logic [8:0] len;
    logic [2:0] wcnt;
    logic stPend;
    logic retireReq;
    logic errFlag;
    logic [13:0] clrIdx;
    logic [13:0] clrEnd;
    logic [BLOCKS-1:0] badTab;
    logic [3:0] progCnt [0:PAGES-1];

    wire [13:0] row = {blk, pg};
    wire [13:0] reqRow = {cmdBlock, cmdPage};
    wire [3:0] cntNow = progCnt[row];
    wire [3:0] reqCnt = progCnt[reqRow];
    wire isErase = (op == OP_ERASE);
    wire isProg = (op == OP_PROG);
    wire isCmdSt = (state == S_PTR) || (state == S_CMD1)
        || (state == S_CMD2) || (state == S_STCMD);
    wire isWrSt = isCmdSt || (state == S_ADDR) || (state == S_WDATA);
    wire isRdSt = (state == S_RDATA) || (state == S_STRD);
    wire stall = (state == S_WDATA) && (ph == 2'h0) && !wrValid;
    wire stepEnd = (ph == PH_END);
    wire [8:0] lastAddr = isErase ? 9'h001 : 9'h002;
    wire [8:0] aSel = isErase ? idx + 9'h001 : idx;
    wire reqProg = (cmdOp == OP_PROG);
    wire reqFull = cmdSpare ? (reqCnt[3:2] >= SPARE_NOP)
        : (reqCnt[1:0] >= MAIN_NOP);
    // Refused before the flash sees a single strobe
    wire refuse = ((reqProg || cmdOp == OP_ERASE) && badTab[cmdBlock])
        || (reqProg && reqFull);
    // Block zero is never retired, the count never falls below the floor
    wire canRetire = (blk != 10'h000) && !badTab[blk]
        && (goodBlockCount > GOOD_MIN);
    wire statFail = ioIn[STAT_FAIL_BIT];
    logic [7:0] curByte;

    assign cmdReady = (state == S_IDLE);
    assign wrReady = (state == S_WDATA) && (ph == 2'h0);

    // Only these defined codes are driven in command states
    always_comb
    begin
        case (state)
            S_PTR: curByte = spare ? CMD_PTR_SPARE : CMD_PTR_MAIN;
            S_CMD1: curByte = isErase ? CMD_ERASE : CMD_PROG;
            S_CMD2: curByte = isErase ? CMD_ERASE_GO : CMD_PROG_GO;
            S_STCMD: curByte = CMD_STATUS;
            S_ADDR:
                case (aSel)
                    9'h000: curByte = col;
                    9'h001: curByte = row[7:0];
                    default: curByte = {2'h0, row[13:8]};
                endcase
            default: curByte = ioOut;
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:
                if (cmdValid)
                begin
                    if (cmdOp == OP_RETIRE || refuse)
                        next_state = S_DONE;
                    else if (cmdOp == OP_ERASE)
                        next_state = S_CMD1;
                    else
                        next_state = S_PTR;
                end
            S_PTR:
                if (stepEnd)
                    next_state = isProg ? S_CMD1 : S_ADDR;
            S_CMD1:
                if (stepEnd)
                    next_state = S_ADDR;
            S_ADDR:
                if (stepEnd && idx == lastAddr)
                    next_state = isErase ? S_CMD2
                        : (isProg ? S_WDATA : S_BUSY);
            S_WDATA:
                if (stepEnd && idx == len - 9'h001)
                    next_state = S_CMD2;
            S_CMD2:
                if (stepEnd)
                    next_state = S_BUSY;
            S_BUSY:
                if (wcnt >= WB_CYC && readyBusyN)
                    next_state = (op == OP_READ) ? S_RDATA
                        : (stPend ? S_STRD : S_STCMD);
            S_STCMD:
                if (stepEnd)
                    next_state = S_BUSY;
            S_STRD:
                if (stepEnd)
                    next_state = isErase ? S_CLR : S_DONE;
            S_RDATA:
                if (stepEnd && idx == len - 9'h001)
                    next_state = S_DONE;
            S_CLR:
                if (clrIdx == clrEnd)
                    next_state = isErase ? S_DONE : S_IDLE;
            S_DONE: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // Reset sweeps all page counts clear before the first request
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= S_CLR;
            op <= OP_READ;
            clrIdx <= 14'h0000;
            clrEnd <= 14'h3FFF;
        end
        else
        begin
            state <= next_state;
            if (state == S_IDLE && cmdValid)
            begin
                op <= nbv_op_e'(cmdOp);
                clrIdx <= {cmdBlock, 4'h0};
                clrEnd <= {cmdBlock, 4'hF};
            end
            else if (state == S_CLR)
                clrIdx <= clrIdx + 14'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (state == S_IDLE && cmdValid)
        begin
            blk <= cmdBlock;
            pg <= cmdPage;
            spare <= cmdSpare;
            col <= cmdCol;
            len <= cmdLen;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || state != next_state)
            ph <= 2'h0;
        else if (isWrSt || isRdSt)
            ph <= stall ? ph : ph + 2'h1;
        if (rst || state != next_state)
            idx <= 9'h000;
        else if ((isWrSt || isRdSt) && stepEnd)
            idx <= idx + 9'h001;
        wcnt <= (state == S_BUSY && wcnt < WB_CYC) ? wcnt + 3'h1
            : (state == S_BUSY ? wcnt : 3'h0);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || state == S_IDLE)
        begin
            stPend <= 1'b0;
            retireReq <= cmdValid && cmdOp == OP_RETIRE && !rst;
            errFlag <= cmdValid && refuse && !rst;
        end
        else if (state == S_STCMD)
            stPend <= 1'b1;
        else if (state == S_STRD && ph == LOW_CYC && statFail)
        begin
            retireReq <= 1'b1;
            errFlag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            badTab <= '0;
            goodBlockCount <= GOOD_RST;
        end
        else if (state == S_DONE && retireReq && canRetire)
        begin
            badTab[blk] <= 1'b1;
            goodBlockCount <= goodBlockCount - 11'h001;
        end
    end

    // Counts rise on the confirm byte only, so a refused page keeps its count
    always_ff @(posedge core_clk)
    begin
        if (state == S_CLR)
            progCnt[clrIdx] <= 4'h0;
        else if (state == S_CMD2 && stepEnd && isProg)
            progCnt[row] <= spare ? cntNow + 4'h4 : cntNow + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            doneValid <= 1'b0;
            doneErr <= 1'b0;
            rdValid <= 1'b0;
            rdData <= 8'h00;
        end
        else
        begin
            doneValid <= (state == S_DONE);
            doneErr <= (state == S_DONE)
                && (errFlag || (retireReq && !canRetire));
            rdValid <= (state == S_RDATA) && (ph == LOW_CYC);
            if (state == S_RDATA && ph == LOW_CYC)
                rdData <= ioIn;
        end
    end

    // Pins from flops; busy leaves latches low and both strobes high
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cle <= 1'b0;
            ale <= 1'b0;
            ceN <= 1'b1;
            weN <= 1'b1;
            readStrobeN <= 1'b1;
            wpN <= 1'b0;
            ioOut <= 8'h00;
            ioOe <= 1'b0;
        end
        else
        begin
            cle <= isCmdSt;
            ale <= (state == S_ADDR);
            ceN <= (state == S_IDLE) || (state == S_CLR)
                || (state == S_DONE);
            weN <= !(isWrSt && ph < LOW_CYC && !stall);
            readStrobeN <= !(isRdSt && ph < LOW_CYC);
            wpN <= 1'b1;
            ioOe <= isWrSt;
            if (wrReady && wrValid)
                ioOut <= wrData;
            else if (isWrSt && ph == 2'h0)
                ioOut <= curByte;
        end
    end

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_goodRange;
        goodBlockCount >= GOOD_MIN && goodBlockCount <= GOOD_RST;
    endproperty
    a_goodRange: assert property (p_goodRange)
        else $error("good block count out of range");

    property p_blockZero;
        !badTab[0];
    endproperty
    a_blockZero: assert property (p_blockZero)
        else $error("block zero retired");

    property p_noBadWrite;
        (state == S_CMD1 || state == S_CMD2) |-> !badTab[blk];
    endproperty
    a_noBadWrite: assert property (p_noBadWrite)
        else $error("program or erase on a bad block");

    property p_nopLimit;
        (state == S_CMD1 && isProg) |-> (spare ? cntNow[3:2] < SPARE_NOP
            : cntNow[1:0] < MAIN_NOP);
    endproperty
    a_nopLimit: assert property (p_nopLimit)
        else $error("partial program limit exceeded");

    property p_busyRead;
        (state == S_BUSY) |-> readStrobeN ##1 readStrobeN;
    endproperty
    a_busyRead: assert property (p_busyRead)
        else $error("read strobe low while busy");

    sequence s_busyTwo;
        (state == S_BUSY) [*2];
    endsequence
    property p_busyQuiet;
        s_busyTwo |-> !cle && !ale && !ceN && weN && readStrobeN;
    endproperty
    a_busyQuiet: assert property (p_busyQuiet)
        else $error("control pins not quiet while busy");

    property p_legalCmd;
        $rose(weN) && cle |-> nbv_legal(ioOut);
    endproperty
    a_legalCmd: assert property (p_legalCmd)
        else $error("undefined command byte latched");

    property p_latchFrame;
        !weN |-> !(cle && ale) && !ceN && wpN && ioOe && readStrobeN;
    endproperty
    a_latchFrame: assert property (p_latchFrame)
        else $error("write strobe outside a proper frame");

    property p_retireFail;
        (state == S_STRD && ph == LOW_CYC && statFail && blk != 10'h000
            && !badTab[blk] && goodBlockCount > GOOD_MIN)
            |-> ##[1:20] badTab[blk];
    endproperty
    a_retireFail: assert property (p_retireFail)
        else $error("failed block not retired");

    property p_retireZero;
        (state == S_DONE && op == OP_RETIRE && blk == 10'h000)
            |=> doneValid && doneErr;
    endproperty
    a_retireZero: assert property (p_retireZero)
        else $error("retire of block zero not refused");
endmodule

// >>> design/nbv_pkg.sv
/*
 * Constants, command codes, operations and states of the host-side
 * sequencer for a small NAND flash.
 * Assumes a single 50 MHz clock and an 8-bit asynchronous flash port.
 */
package nbv_pkg;
    localparam int CLK_NS = 20;
    localparam int BLOCKS = 1024;
    localparam int PAGES = 16384;
    localparam logic [10:0] GOOD_RST = 11'h400;
    localparam logic [10:0] GOOD_MIN = 11'h3F6;
    localparam logic [1:0] MAIN_NOP = 2'h2;
    localparam logic [1:0] SPARE_NOP = 2'h3;
    localparam int STAT_FAIL_BIT = 0;
    // Strobe low time, least 25 ns, rounded up
    localparam int LOW_NS = 25;
    localparam logic [1:0] LOW_CYC = 2'((LOW_NS + CLK_NS - 1) / CLK_NS);
    // High part pads each cycle well past the 50 ns cycle time
    localparam logic [1:0] PH_END = 2'h3;
    // Write high to busy, longest 100 ns, rounded down
    localparam int WB_NS = 100;
    localparam logic [2:0] WB_CYC = 3'(WB_NS / CLK_NS);
    localparam logic [7:0] CMD_PTR_MAIN = 8'h00;
    localparam logic [7:0] CMD_PTR_SPARE = 8'h50;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    typedef enum logic [1:0]
    {
        OP_READ = 2'h0,
        OP_PROG = 2'h1,
        OP_ERASE = 2'h2,
        OP_RETIRE = 2'h3
    } nbv_op_e;

    typedef enum logic [11:0]
    {
        S_IDLE = 12'h001,
        S_PTR = 12'h002,
        S_CMD1 = 12'h004,
        S_ADDR = 12'h008,
        S_WDATA = 12'h010,
        S_CMD2 = 12'h020,
        S_BUSY = 12'h040,
        S_STCMD = 12'h080,
        S_STRD = 12'h100,
        S_RDATA = 12'h200,
        S_CLR = 12'h400,
        S_DONE = 12'h800
    } nbv_state_e;

    function automatic logic nbv_legal(input logic [7:0] b);
        nbv_legal = (b == CMD_PTR_MAIN) || (b == CMD_PTR_SPARE)
            || (b == CMD_PROG) || (b == CMD_PROG_GO) || (b == CMD_ERASE)
            || (b == CMD_ERASE_GO) || (b == CMD_STATUS);
    endfunction
endpackage

// >>> verif/nbv_flash_model.sv
/*
 * Behavioural flash device for the host sequencer bench.
 * Assumes host pins change on core_clk; the bench sets the busy length
 * and whether a status read reports a failure.
 */
`timescale 1ns/1ns
module nbv_flash_model
    import nbv_pkg::*;
(
    input wire logic core_clk,
    input wire logic cle,
    input wire logic ale,
    input wire logic ceN,
    input wire logic weN,
    input wire logic readStrobeN,
    input wire logic wpN,
    input wire logic [7:0] ioOut,
    output logic [7:0] ioIn,
    output logic readyBusyN,
    input wire logic [7:0] busyLen,
    input wire logic failNext
);
    logic weQ = 1'b1;
    logic strobeQ = 1'b1;
    logic busyQ = 1'b0;
    logic [7:0] lastData = 8'h00;
    logic inStat = 1'b0;
    logic [7:0] col = 8'h00;
    logic [7:0] lastOut = 8'h00;
    logic [7:0] cmd = 8'h00;
    int addrCnt = 0;
    int busyCnt = 0;
    int nBytes = 0;
    int viol = 0;
    logic drive;
    logic [7:0] dout;
    logic wrEdge;
    assign drive = !ceN && !readStrobeN;
    assign wrEdge = weN && !weQ && !ceN;
    assign dout = inStat ? {7'h00, failNext} : col ^ 8'h5A;
    // Released bus flips, so a stale byte never reads as good
    assign ioIn = drive ? dout : ~lastOut;
    assign readyBusyN = busyCnt == 0;
    always @(posedge core_clk)
    begin
        weQ <= weN;
        strobeQ <= readStrobeN;
        busyQ <= busyCnt > 0;
        if (drive)
            lastOut <= dout;
        if (busyCnt > 0)
            busyCnt <= busyCnt - 1;
        // Latch pins hold one cycle past the strobe that starts busy
        if (busyQ && busyCnt > 0
            && (!readStrobeN || !weN || cle || ale || ceN))
            viol <= viol + 1;
        if (readStrobeN && !strobeQ && !inStat)
            col <= col + 8'h01;
        if (wrEdge)
            nBytes <= nBytes + 1;
        if (wrEdge && !cle && !ale)
            lastData <= ioOut;
        if (wrEdge && cle)
        begin
            cmd <= ioOut;
            addrCnt <= 0;
            inStat <= ioOut == CMD_STATUS;
            if (!wpN || !(ioOut inside {CMD_PTR_MAIN, CMD_PTR_SPARE,
                CMD_PROG, CMD_PROG_GO, CMD_ERASE, CMD_ERASE_GO, CMD_STATUS}))
                viol <= viol + 1;
            if (ioOut == CMD_PROG_GO || ioOut == CMD_ERASE_GO)
                busyCnt <= busyLen;
        end
        if (wrEdge && ale)
        begin
            if (addrCnt == 0 && cmd != CMD_ERASE)
                col <= ioOut;
            addrCnt <= addrCnt + 1;
            // Read goes busy after its last address byte
            if (addrCnt == 2 && (cmd == CMD_PTR_MAIN || cmd == CMD_PTR_SPARE))
                busyCnt <= busyLen;
        end
    end
endmodule

// >>> verif/nbv_host_tb.sv
/*
 * Bench for the host sequencer: a bench model of bad blocks, good count
 * and page program counts is compared at every finished request.
 * Assumes the flash model on the far side of the pins.
 */
`timescale 1ns/1ns
module nbv_host_tb
    import nbv_pkg::*;
;
    logic core_clk, rst, cmdValid, cmdReady, cmdSpare, wrValid, wrReady;
    logic [1:0] cmdOp;
    logic [9:0] cmdBlock;
    logic [3:0] cmdPage;
    logic [7:0] cmdCol, wrData, rdData, ioOut, ioIn, busyLen;
    logic [8:0] cmdLen;
    logic rdValid, doneValid, doneErr, cle, ale, ceN, weN, readStrobeN;
    logic wpN, ioOe, readyBusyN, flFail;
    logic [10:0] goodBlockCount;
    int error_cnt = 0;
    int compares = 0;
    int cnt = 1024;
    bit bad [1024];
    int pc [32768];
    logic [7:0] rq [$];

    nbv_host nbv_host_i (.core_clk(core_clk), .rst(rst),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdBlock(cmdBlock), .cmdPage(cmdPage), .cmdSpare(cmdSpare),
        .cmdCol(cmdCol), .cmdLen(cmdLen), .wrData(wrData),
        .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData),
        .rdValid(rdValid), .doneValid(doneValid), .doneErr(doneErr),
        .goodBlockCount(goodBlockCount), .cle(cle), .ale(ale), .ceN(ceN),
        .weN(weN), .readStrobeN(readStrobeN), .wpN(wpN), .ioOut(ioOut),
        .ioOe(ioOe), .ioIn(ioIn), .readyBusyN(readyBusyN));
    nbv_flash_model nbv_flash_model_i (.core_clk(core_clk), .cle(cle),
        .ale(ale), .ceN(ceN), .weN(weN), .readStrobeN(readStrobeN),
        .wpN(wpN), .ioOut(ioOut), .ioIn(ioIn), .readyBusyN(readyBusyN),
        .busyLen(busyLen), .failNext(flFail));

    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask

    task automatic waitRdy;
        int k;
        // Sample settled outputs, two ns after each edge
        for (k = 0; k < 20000 && cmdReady !== 1'b1; k++)
        begin
            @(posedge core_clk);
            #2;
        end
        if (k >= 20000)
        begin
            chk(1'b0, "ready timeout");
            stop_test();
        end
    endtask

    // Bench model first, then the request, then compare at done
    task automatic req(input int op, b, p, s, n, c);
        int k;
        int i;
        int nb;
        int eb;
        logic e;
        e = 0;
        eb = 0;
        i = b * 32 + p * 2 + s;
        nb = nbv_flash_model_i.nBytes;
        if (op == 3)
            e = b == 0 || bad[b] || cnt == 1014;
        else if (op == 0)
            eb = 4;
        else if (bad[b] || (op == 1 && pc[i] == (s ? 3 : 2)))
            e = 1;
        else
        begin
            eb = op == 1 ? n + 7 : 5;
            pc[i] = op == 1 ? pc[i] + 1 : pc[i];
            for (k = 0; k < 32 && op == 2; k++)
                pc[b * 32 + k] = 0;
            e = flFail;
        end
        if (e && op != 3 && eb > 0 || !e && op == 3)
            cnt--;
        bad[b] = bad[b] || (e && op != 3 && eb > 0) || (!e && op == 3);
        rq.delete();
        waitRdy();
        cmdValid = 1;
        cmdOp = 2'(op);
        cmdBlock = 10'(b);
        cmdPage = 4'(p);
        cmdSpare = 1'(s);
        cmdLen = 9'(n);
        cmdCol = 8'(c);
        wrValid = op == 1;
        @(posedge core_clk);
        #2 cmdValid = 0;
        for (k = 0; k < 9000; k++)
        begin
            @(posedge core_clk);
            #2;
            if (rdValid === 1'b1)
                rq.push_back(rdData);
            if (doneValid === 1'b1)
                break;
            // Byte slot open: this value is taken at the next edge
            if (wrReady === 1'b1)
                wrData = 8'($urandom);
        end
        if (k >= 9000)
        begin
            chk(1'b0, "no done");
            stop_test();
        end
        chk(doneErr === e, "done error flag");
        chk(goodBlockCount === 11'(cnt), "good count");
        chk(nbv_flash_model_i.nBytes - nb == eb, "byte count");
        if (op == 1 && eb > 0)
            chk(nbv_flash_model_i.lastData === wrData, "data");
        chk(rq.size() == (op == 0 ? n : 0), "read length");
        foreach (rq[j])
            chk(rq[j] === 8'((c + j) ^ 8'h5A), "read data");
        wrValid = 0;
    endtask

    initial
    begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        int b1;
        int c;
        int p;
        int k;
        rst = 1;
        {cmdValid, cmdOp, cmdBlock, cmdPage, cmdSpare} = 18'h00000;
        {cmdCol, cmdLen, wrData, wrValid, flFail} = 27'h0000000;
        busyLen = 8'h01;
        k = $urandom(32'h1E9BCA5D);
        repeat (6) @(posedge core_clk);
        chk(goodBlockCount === 11'h400, "count at reset");
        #2 rst = 0;
        b1 = 1 + $urandom % 1023;
        c = b1 % 1000 + 10;
        p = $urandom % 16;
        req(3, 0, 0, 0, 1, 0);
        req(3, b1, 0, 0, 1, 0);
        req(3, b1, 0, 0, 1, 0);
        req(1, b1, p, 0, 4, 0);
        req(2, b1, 0, 0, 1, 0);
        $display("test bad blocks done");
        for (k = 0; k < 7; k++)
        begin
            busyLen = k[0] ? 8'h28 : 8'h01;
            req(1, c, p, k > 2, 1 + $urandom % 8, $urandom % 8);
        end
        req(0, c, p, 0, 1 + $urandom % 8, $urandom % 200);
        req(0, b1, p, 1, 3, 2);
        req(2, c, 0, 0, 1, 0);
        req(1, c, p, 0, 2, 0);
        $display("test partial program done");
        flFail = 1;
        req(1, c, p ^ 1, 0, 1, 0);
        flFail = 0;
        req(1, c, p, 1, 1, 0);
        for (k = 1; cnt > 1014; k++)
            req(3, k, 0, 0, 1, 0);
        req(3, 1023, 0, 0, 1, 0);
        $display("test count floor done");
        chk(nbv_flash_model_i.viol == 0, "pins");
        stop_test();
    end
endmodule
